// File: verilog/hsfsb_defines.svh
// Offsets, bit positions and cause codes of the fault status bank
`ifndef HSFSB_DEFINES_SVH
`define HSFSB_DEFINES_SVH
`define HSFSB_ADDR_INPUT 8'h7C
`define HSFSB_ADDR_TEMP 8'h7D
`define HSFSB_ADDR_MAKER 8'h80
`define HSFSB_RESET_VALUE 8'h00
`define HSFSB_BIT_IN_OV_FAULT 7
`define HSFSB_BIT_IN_OV_WARN 6
`define HSFSB_BIT_IN_UV_WARN 5
`define HSFSB_BIT_IN_UV_FAULT 4
`define HSFSB_BIT_IN_OP_WARN 0
`define HSFSB_BIT_OVERTEMPERATURE_FAULT 7
`define HSFSB_BIT_OT_WARN 6
`define HSFSB_BIT_PT_HEALTH 7
`define HSFSB_BIT_UV_LIVE 6
`define HSFSB_BIT_OV_LIVE 5
`define HSFSB_BIT_SEVERE_OC 4
`define HSFSB_BIT_CUR_LIMIT 3
`define HSFSB_CAUSE_MSB 2
`define HSFSB_CAUSE_NONE 3'h0
`define HSFSB_CAUSE_OT 3'h1
`define HSFSB_CAUSE_OC 3'h2
`define HSFSB_CAUSE_PT 3'h3
`define HSFSB_CAUSE_UV 3'h4
`define HSFSB_CAUSE_OV 3'h6
`endif

// File: verilog/hsfsb_pkg.sv
// Types shared by the fault status bank
package hsfsb_pkg;
  typedef logic [2:0] hsfsb_cause_type;
  typedef logic [7:0] hsfsb_byte_type;
endpackage

// File: verilog/hsfsb_sync.sv
// Two-flop synchroniser for asynchronous comparator pins
`timescale 1ns/1ps
module hsfsb_sync #(
  parameter int WIDTH = 2
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1_reg;

  // First stage feeds only the second stage
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      stage1_reg <= '0;
      o_sync <= '0;
    end else begin
      stage1_reg <= i_async;
      o_sync <= stage1_reg;
    end
  end
endmodule

// File: verilog/hsfsb_bank.sv
// Hot swap fault status register bank
// Summary of operation
// [RL1] Overvoltage pin sets latched input bit 7
// [RL2] Monitor overvoltage warning latches input bit 6
// [RL3] Monitor undervoltage warning latches input bit 5
// [RL4] Undervoltage pin sets latched input bit 4
// [RL5] Reserved bits read as zero
// [RL6] Input overpower warning latches input bit 0
// [RL7] Overtemperature fault latches temperature bit 7
// [RL8] Overtemperature warning latches temperature bit 6
// [RL9] Pass transistor fault latches maker bit 7
// [RL10] Maker bit 6 follows undervoltage comparator live
// [RL11] Maker bit 5 follows overvoltage comparator live
// [RL12] Severe overcurrent latches maker bit 4
// [RL13] Current limiting latches maker bit 3 immediately
// [RL14] Timed overcurrent only after limit timer expires
// [RL15] Last shutdown cause held until clear
// [RL16] Cause 000 when working or commanded off
// [RL17] Codes 001 temp, 010 overcurrent, 011 transistor
// [RL18] Codes 100 undervoltage, 110 overvoltage
// [RL19] All status registers reset to zero
// [RL20] Input summary set when any input bit
// [RL21] Codes 101 and 111 never produced
// [RL22] Latched flags clear only on host clear
`timescale 1ns/1ps
`include "hsfsb_defines.svh"
module hsfsb_bank
  import hsfsb_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_overvoltage_sense_pin,
  input wire logic i_undervoltage_sense_pin,
  input wire logic i_input_overvoltage_warning,
  input wire logic i_input_undervoltage_warning,
  input wire logic i_input_overpower_warning,
  input wire logic i_overtemperature_fault,
  input wire logic i_overtemperature_warning,
  input wire logic i_pass_transistor_health_fault,
  input wire logic i_severe_overcurrent_fault,
  input wire logic i_current_limiting,
  input wire logic i_limit_timer_expired,
  input wire logic i_hot_swap_shutdown,
  input wire logic i_status_clear,
  input wire logic [7:0] i_read_addr,
  output logic [7:0] o_read_data,
  output logic o_read_hit,
  output logic o_input_summary,
  output logic o_timed_output_overcurrent_fault
);
  logic [1:0] pins_sync;
  logic ov_live;
  logic uv_live;
  logic input_overvoltage_fault_reg;
  logic input_overvoltage_warning_reg;
  logic input_undervoltage_warning_reg;
  logic input_undervoltage_fault_reg;
  logic input_overpower_warning_reg;
  logic overtemperature_fault_reg;
  logic overtemperature_warning_reg;
  logic pass_transistor_health_fault_reg;
  logic severe_overcurrent_fault_reg;
  logic current_limiting_active_flag_reg;
  logic timed_oc_reg;
  logic shutdown_seen_reg;
  hsfsb_cause_type last_shutdown_cause_reg;
  hsfsb_cause_type cause_next;
  hsfsb_byte_type input_supply_status;
  hsfsb_byte_type temperature_status;
  hsfsb_byte_type maker_specific_status;
  logic [7:0] read_data_reg;
  logic read_hit_reg;

  // Comparator pins are asynchronous to the clock
  hsfsb_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_async({i_overvoltage_sense_pin, i_undervoltage_sense_pin}),
    .o_sync(pins_sync)
  );
  assign ov_live = pins_sync[1];
  assign uv_live = pins_sync[0];

  // Sticky update shared by every latched flag: a new event in the clear
  // cycle wins over the clear, so a fault is never lost to a racing clear
  // [RL22] clear only on host
  function automatic logic sticky_next(input logic set_now, input logic held,
    input logic clear_now);
    return set_now | (held & ~clear_now);
  endfunction

  // [RL19] flags reset to zero
  // Pin fault lags the pin by three edges
  // [RL1] overvoltage pin latch
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      input_overvoltage_fault_reg <= 1'b0;
    end else begin
      input_overvoltage_fault_reg <= sticky_next(ov_live,
        input_overvoltage_fault_reg, i_status_clear);
    end
  end

  // Monitor warning may be a level or a pulse
  // [RL2] overvoltage warning latch
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      input_overvoltage_warning_reg <= 1'b0;
    end else begin
      input_overvoltage_warning_reg <= sticky_next(i_input_overvoltage_warning,
        input_overvoltage_warning_reg, i_status_clear);
    end
  end

  // Monitor undervoltage warning
  // [RL3] undervoltage warning latch
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      input_undervoltage_warning_reg <= 1'b0;
    end else begin
      input_undervoltage_warning_reg <= sticky_next(i_input_undervoltage_warning,
        input_undervoltage_warning_reg, i_status_clear);
    end
  end

  // Pin fault stays set after the pin recovers
  // [RL4] undervoltage pin latch
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      input_undervoltage_fault_reg <= 1'b0;
    end else begin
      input_undervoltage_fault_reg <= sticky_next(uv_live,
        input_undervoltage_fault_reg, i_status_clear);
    end
  end

  // Input power warning
  // [RL6] overpower warning latch
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      input_overpower_warning_reg <= 1'b0;
    end else begin
      input_overpower_warning_reg <= sticky_next(i_input_overpower_warning,
        input_overpower_warning_reg, i_status_clear);
    end
  end

  // Temperature fault from the converter measurement
  // [RL7] overtemperature fault latch
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      overtemperature_fault_reg <= 1'b0;
    end else begin
      overtemperature_fault_reg <= sticky_next(i_overtemperature_fault,
        overtemperature_fault_reg, i_status_clear);
    end
  end

  // Temperature warning
  // [RL8] overtemperature warning latch
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      overtemperature_warning_reg <= 1'b0;
    end else begin
      overtemperature_warning_reg <= sticky_next(i_overtemperature_warning,
        overtemperature_warning_reg, i_status_clear);
    end
  end

  // Pass transistor health
  // [RL9] transistor health latch
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      pass_transistor_health_fault_reg <= 1'b0;
    end else begin
      pass_transistor_health_fault_reg <= sticky_next(i_pass_transistor_health_fault,
        pass_transistor_health_fault_reg, i_status_clear);
    end
  end

  // Severe overcurrent from the fast detector
  // [RL12] severe overcurrent latch
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      severe_overcurrent_fault_reg <= 1'b0;
    end else begin
      severe_overcurrent_fault_reg <= sticky_next(i_severe_overcurrent_fault,
        severe_overcurrent_fault_reg, i_status_clear);
    end
  end

  // Limiting flag needs no timer, so it leads the timed fault
  // [RL13] immediate limiting latch
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      current_limiting_active_flag_reg <= 1'b0;
    end else begin
      current_limiting_active_flag_reg <= sticky_next(i_current_limiting,
        current_limiting_active_flag_reg, i_status_clear);
    end
  end

  // Timer expiry alone is ignored; limiting must still be active
  // [RL14] timed fault needs expiry
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      timed_oc_reg <= 1'b0;
    end else begin
      timed_oc_reg <= sticky_next(i_current_limiting & i_limit_timer_expired,
        timed_oc_reg, i_status_clear);
    end
  end

  // Cause priority when several faults coincide; only defined codes exist
  // [RL17] cause encodings
  // [RL18] voltage cause encodings
  // [RL21] no unused codes
  always_comb begin
    if (ov_live) begin
      cause_next = `HSFSB_CAUSE_OV;
    end else if (uv_live) begin
      cause_next = `HSFSB_CAUSE_UV;
    end else if (i_pass_transistor_health_fault) begin
      cause_next = `HSFSB_CAUSE_PT;
    end else if (i_current_limiting & i_limit_timer_expired) begin
      cause_next = `HSFSB_CAUSE_OC;
    end else if (i_overtemperature_fault) begin
      cause_next = `HSFSB_CAUSE_OT;
    end else begin
      // Commanded shutdown reports no fault
      cause_next = `HSFSB_CAUSE_NONE;
    end
  end

  // Cause captured on the first shutdown edge, then held
  // [RL15] hold cause until clear
  // [RL16] zero while working
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      last_shutdown_cause_reg <= `HSFSB_CAUSE_NONE;
      shutdown_seen_reg <= 1'b0;
    end else if (i_hot_swap_shutdown & ~shutdown_seen_reg) begin
      last_shutdown_cause_reg <= cause_next;
      shutdown_seen_reg <= 1'b1;
    end else if (i_status_clear) begin
      last_shutdown_cause_reg <= `HSFSB_CAUSE_NONE;
      shutdown_seen_reg <= i_hot_swap_shutdown;
    end else if (~i_hot_swap_shutdown) begin
      shutdown_seen_reg <= 1'b0;
    end
  end

  // Register images, reserved bits zero
  // [RL5] reserved read zero
  always_comb begin
    input_supply_status = `HSFSB_RESET_VALUE;
    input_supply_status[`HSFSB_BIT_IN_OV_FAULT] = input_overvoltage_fault_reg;
    input_supply_status[`HSFSB_BIT_IN_OV_WARN] = input_overvoltage_warning_reg;
    input_supply_status[`HSFSB_BIT_IN_UV_WARN] = input_undervoltage_warning_reg;
    input_supply_status[`HSFSB_BIT_IN_UV_FAULT] = input_undervoltage_fault_reg;
    input_supply_status[`HSFSB_BIT_IN_OP_WARN] = input_overpower_warning_reg;
    temperature_status = `HSFSB_RESET_VALUE;
    temperature_status[`HSFSB_BIT_OVERTEMPERATURE_FAULT] = overtemperature_fault_reg;
    temperature_status[`HSFSB_BIT_OT_WARN] = overtemperature_warning_reg;
    maker_specific_status = `HSFSB_RESET_VALUE;
    maker_specific_status[`HSFSB_BIT_PT_HEALTH] = pass_transistor_health_fault_reg;
    // [RL10] live undervoltage bit
    maker_specific_status[`HSFSB_BIT_UV_LIVE] = uv_live;
    // [RL11] live overvoltage bit
    maker_specific_status[`HSFSB_BIT_OV_LIVE] = ov_live;
    maker_specific_status[`HSFSB_BIT_SEVERE_OC] = severe_overcurrent_fault_reg;
    maker_specific_status[`HSFSB_BIT_CUR_LIMIT] = current_limiting_active_flag_reg;
    maker_specific_status[`HSFSB_CAUSE_MSB:0] = last_shutdown_cause_reg;
  end

  // Address decode of the three mapped status bytes
  function automatic logic addr_mapped(input logic [7:0] addr);
    return (addr == `HSFSB_ADDR_INPUT) || (addr == `HSFSB_ADDR_TEMP) ||
      (addr == `HSFSB_ADDR_MAKER);
  endfunction

  // Registered read port; unmapped addresses read zero
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      read_data_reg <= `HSFSB_RESET_VALUE;
    end else begin
      unique case (i_read_addr)
        `HSFSB_ADDR_INPUT: begin
          read_data_reg <= input_supply_status;
        end
        `HSFSB_ADDR_TEMP: begin
          read_data_reg <= temperature_status;
        end
        `HSFSB_ADDR_MAKER: begin
          read_data_reg <= maker_specific_status;
        end
        default: begin
          read_data_reg <= `HSFSB_RESET_VALUE;
        end
      endcase
    end
  end

  // Hit kept apart so a host can tell an all-zero byte from a miss
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      read_hit_reg <= 1'b0;
    end else begin
      read_hit_reg <= addr_mapped(i_read_addr);
    end
  end

  assign o_read_data = read_data_reg;
  assign o_read_hit = read_hit_reg;
  assign o_timed_output_overcurrent_fault = timed_oc_reg;
  // [RL20] input summary bit
  assign o_input_summary = |input_supply_status;
endmodule

// File: dv/hsfsb_bank_assertions.sv
// Port-level checks on the fault status bank
`timescale 1ns/1ps
module hsfsb_bank_assertions (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_overvoltage_sense_pin,
  input wire logic i_current_limiting,
  input wire logic i_limit_timer_expired,
  input wire logic i_status_clear,
  input wire logic [7:0] i_read_addr,
  input wire logic [7:0] o_read_data,
  input wire logic o_read_hit,
  input wire logic o_input_summary,
  input wire logic o_timed_output_overcurrent_fault
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // Limiting alone must never raise the timed flag
  sequence s_timed_cause;
    i_current_limiting && i_limit_timer_expired;
  endsequence
  // Pin needs two sync stages plus the latch stage
  sequence s_ov_held;
    (i_overvoltage_sense_pin && !i_status_clear)[*3];
  endsequence
  wire mapped = i_read_addr inside {8'h7C, 8'h7D, 8'h80};
  a_map_hit: assert property (mapped |=> o_read_hit)
    else $error("mapped address gave no hit");
  a_unmap_zero: assert property (!mapped |=> !o_read_hit && o_read_data == 8'h00)
    else $error("unmapped address not zero");
  a_input_resv: assert property (i_read_addr == 8'h7C |=> o_read_data[3:1] == 3'h0)
    else $error("input reserved bits set");
  a_temp_resv: assert property (i_read_addr == 8'h7D |=> o_read_data[5:0] == 6'h00)
    else $error("temperature reserved bits set");
  a_cause_legal: assert property (i_read_addr == 8'h80 |=>
    !(o_read_data[2:0] inside {3'h5, 3'h7})) else $error("unused cause code");
  a_timed_set: assert property (s_timed_cause |=> o_timed_output_overcurrent_fault)
    else $error("timed flag not set");
  a_timed_only: assert property ($rose(o_timed_output_overcurrent_fault) |->
    $past(i_current_limiting && i_limit_timer_expired)) else $error("timed flag early");
  a_timed_hold: assert property (o_timed_output_overcurrent_fault && !i_status_clear
    |=> o_timed_output_overcurrent_fault) else $error("timed flag dropped");
  a_ov_pin_latch: assert property (s_ov_held |=> o_input_summary)
    else $error("overvoltage pin not latched");
endmodule

// File: dv/hsfsb_host.sv
// Host model reading status bytes one address at a time
`timescale 1ns/1ps
module hsfsb_host (
  input wire logic i_mclk,
  input wire logic [7:0] i_read_data,
  input wire logic i_read_hit,
  output logic [7:0] o_read_addr
);
  initial o_read_addr = 8'h00;
  // Address held until the answer is taken; read settles mid-cycle
  task automatic rd(input logic [7:0] a, output logic [8:0] v);
    @(posedge i_mclk) o_read_addr <= a;
    @(posedge i_mclk);
    @(negedge i_mclk) v = {i_read_hit, i_read_data};
  endtask
endmodule

// File: dv/hsfsb_bank_bench.sv
// Self-checking bench for the hot swap fault status bank
`timescale 1ns/1ps
module hsfsb_bank_bench;
  import hsfsb_pkg::*;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic i_status_clear = 1'b0;
  logic [11:0] ev = '0;
  logic [7:0] addr;
  logic [7:0] rdata;
  logic hit, summ, timed;
  int n_fail = 0;
  int compares = 0;
  int m[3];
  int mt;
  hsfsb_byte_type ra[3] = '{8'h7C, 8'h7D, 8'h80};
  // Register index and bit for each synchronous event line
  int er[8] = '{0, 0, 0, 1, 1, 2, 2, 2};
  int eb[8] = '{6, 5, 0, 7, 6, 7, 4, 3};
  logic [11:0] mk[11] = '{12'h001, 12'h002, 12'h004, 12'h008, 12'h010, 12'h020,
    12'h040, 12'h080, 12'h180, 12'h400, 12'h800};
  int cd[11] = '{0, 0, 0, 1, 0, 3, 0, 0, 2, 6, 4};
  // Free-running 40 MHz clock
  always #12.5 i_mclk = ~i_mclk;
  hsfsb_bank i_hsfsb_bank (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_overvoltage_sense_pin(ev[10]), .i_undervoltage_sense_pin(ev[11]),
    .i_input_overvoltage_warning(ev[0]), .i_input_undervoltage_warning(ev[1]),
    .i_input_overpower_warning(ev[2]), .i_overtemperature_fault(ev[3]),
    .i_overtemperature_warning(ev[4]), .i_pass_transistor_health_fault(ev[5]),
    .i_severe_overcurrent_fault(ev[6]), .i_current_limiting(ev[7]),
    .i_limit_timer_expired(ev[8]), .i_hot_swap_shutdown(ev[9]),
    .i_status_clear(i_status_clear), .i_read_addr(addr), .o_read_data(rdata),
    .o_read_hit(hit), .o_input_summary(summ), .o_timed_output_overcurrent_fault(timed));
  hsfsb_host i_hsfsb_host (.i_mclk(i_mclk), .i_read_data(rdata), .i_read_hit(hit),
    .o_read_addr(addr));
  // Count every compare, report each mismatch at once
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Live comparator bits come from the pins, never from the latch
  task automatic rdall();
    logic [8:0] v;
    for (int r = 0; r < 3; r++) begin
      i_hsfsb_host.rd(ra[r], v);
      chk({1'b0, v}, {2'b01, 8'(m[r] | (r == 2 ? {ev[11], ev[10], 5'h0} : 0))});
    end
    chk({8'h0, summ, timed}, {8'h0, m[0] != 0, mt[0]});
  endtask
  task automatic summarize();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence: one fault source per pass, then shutdown, release, clear
  initial begin
    logic [8:0] v;
    hsfsb_byte_type a;
    void'($urandom(8136));
    m = '{0, 0, 0};
    mt = 0;
    repeat (12) @(posedge i_mclk);
    i_reset <= 1'b0;
    rdall();
    repeat (4) begin
      a = 8'($urandom);
      if (a inside {8'h7C, 8'h7D, 8'h80})
        a = 8'hFF;
      i_hsfsb_host.rd(a, v);
      chk({1'b0, v}, 10'h000);
    end
    for (int i = 0; i < 11; i++) begin
      @(posedge i_mclk) ev <= mk[i];
      for (int k = 0; k < 8; k++)
        if (mk[i][k])
          m[er[k]] |= 1 << eb[k];
      m[0] |= {mk[i][10], 2'b0, mk[i][11], 4'h0};
      mt = mk[i][7] & mk[i][8];
      repeat (4) @(posedge i_mclk);
      rdall();
      @(posedge i_mclk) ev[9] <= 1'b1;
      m[2] |= cd[i];
      repeat (2) @(posedge i_mclk);
      rdall();
      @(posedge i_mclk) ev <= '0;
      repeat ($urandom_range(4, 8)) @(posedge i_mclk);
      rdall();
      @(posedge i_mclk) i_status_clear <= 1'b1;
      @(posedge i_mclk) i_status_clear <= 1'b0;
      m = '{0, 0, 0};
      mt = 0;
      repeat (2) @(posedge i_mclk);
      rdall();
    end
    // An event in the clear cycle must survive the clear
    @(posedge i_mclk) ev <= 12'h001;
    i_status_clear <= 1'b1;
    m[0] = 32'h40;
    @(posedge i_mclk) ev <= '0;
    i_status_clear <= 1'b0;
    repeat (2) @(posedge i_mclk);
    rdall();
    summarize();
  end
  // Watchdog far beyond the roughly 500-cycle run
  initial begin
    repeat (20000) @(posedge i_mclk);
    n_fail++;
    summarize();
  end
endmodule
bind hsfsb_bank hsfsb_bank_assertions i_hsfsb_bank_assertions (.i_mclk(i_mclk),
  .i_reset(i_reset), .i_overvoltage_sense_pin(i_overvoltage_sense_pin),
  .i_current_limiting(i_current_limiting), .i_limit_timer_expired(i_limit_timer_expired),
  .i_status_clear(i_status_clear), .i_read_addr(i_read_addr), .o_read_data(o_read_data),
  .o_read_hit(o_read_hit), .o_input_summary(o_input_summary),
  .o_timed_output_overcurrent_fault(o_timed_output_overcurrent_fault));
